// File: include/eds_pkg.sv
// constants and types for the data-space address and stack check block
package eds_pkg;
    // address widths
    localparam int unsigned EA_W    = 16;
    localparam int unsigned ADDR_W  = 24;
    localparam int unsigned WPAGE_W = 9;
    localparam int unsigned RPAGE_W = 10;
    // address map boundaries
    localparam logic [15:0] NEAR_TOP    = 16'h2000;
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    localparam logic [15:0] SP_STEP     = 16'h0002;
    localparam logic [8:0]  PAGE_NONE   = 9'h000;
    // register byte offsets on the slave bus
    localparam logic [4:0] OFF_RPAGE     = 5'h00;
    localparam logic [4:0] OFF_WPAGE     = 5'h04;
    localparam logic [4:0] OFF_STACK_LIM = 5'h08;
    localparam logic [4:0] OFF_STACK_PTR = 5'h0c;
    localparam logic [4:0] OFF_TRAP_STAT = 5'h10;
    localparam logic [4:0] OFF_LAST_ADDR = 5'h14;
    // values after reset
    localparam logic [9:0]  RPAGE_RST = 10'h001;
    localparam logic [8:0]  WPAGE_RST = 9'h001;
    localparam logic [15:0] SP_RST    = 16'h0800;
    // trap status bit positions
    localparam int unsigned TRAP_ADDR_BIT  = 0;
    localparam int unsigned TRAP_STACK_BIT = 1;
    // extra cycles an extended-space read holds the core
    localparam int unsigned EDS_READ_EXTRA = 1;
    // what a stack push carries
    typedef enum logic [1:0] {
        SRC_DATA,
        SRC_PC_LO,
        SRC_PC_CALL,
        SRC_PC_EXC
    } push_src_t;
endpackage

// File: sim/core_model.sv
// model of the core's address generation side issuing data accesses
`timescale 1ns/1ps
module core_model (
    // clock and handshake
    input  wire logic        CLK_I,
    input  wire logic        ACC_READY_I,
    // access request
    output logic             ACC_VALID_O,
    output logic             ACC_WRITE_O,
    output logic             ACC_RMW_O,
    output logic             ACC_USES_SP_O,
    output logic [15:0]      ACC_EA_O
);
    // idle request lines from time zero
    initial begin
        ACC_VALID_O   = 1'b0;
        ACC_WRITE_O   = 1'b0;
        ACC_RMW_O     = 1'b0;
        ACC_USES_SP_O = 1'b0;
        ACC_EA_O      = 16'h0000;
    end
    // called just after an edge; holds all until ready seen at the edge
    // ready is registered, so its mid-cycle value is the one sampled
    task automatic issue(input logic w, input logic rmw, input logic sp,
                         input logic [15:0] ea);
        logic rdy;
        ACC_VALID_O   <= 1'b1;
        ACC_WRITE_O   <= w;
        ACC_RMW_O     <= rmw; // no repeat loops issued by this model
        ACC_USES_SP_O <= sp; // sp marks an access checked against stack limit and floor
        ACC_EA_O      <= ea;
        do begin
            @(negedge CLK_I);
            rdy = ACC_READY_I;
            @(posedge CLK_I);
        end while (!rdy);
    endtask
    // drop the request; the address keeps moving so stale values show
    task automatic idle();
        ACC_VALID_O <= 1'b0;
        ACC_EA_O    <= ~ACC_EA_O;
    endtask
endmodule

// File: sim/tb_eds_address_and_stack_check.sv
// self-checking bench for the address and stack check block
`timescale 1ns/1ps
module tb_eds_address_and_stack_check;
    logic CLK_I = 1'b0, RST_N_I = 1'b0;
    logic [4:0] AVS_ADDRESS_I = 5'h00;
    logic AVS_READ_I = 1'b0, AVS_WRITE_I = 1'b0;
    logic [3:0] AVS_BYTEENABLE_I = 4'h3;
    logic [31:0] AVS_WRITEDATA_I = 32'h0, AVS_READDATA_O, rnd = 32'h94d374ff;
    logic AVS_WAITREQUEST_O, ACC_VALID_I, ACC_WRITE_I, ACC_RMW_I;
    logic ACC_USES_SP_I, ACC_READY_O, STK_PUSH_I = 1'b0, STK_POP_I = 1'b0;
    logic [15:0] ACC_EA_I, STK_WDATA_I = 16'h0, STK_ADDR_O, STK_WDATA_O;
    eds_pkg::push_src_t STK_SRC_I = eds_pkg::SRC_DATA;
    logic [22:0] PC_I = 23'h0;
    logic [7:0] SRL_I = 8'h00;
    logic DAT_VALID_O, DAT_WRITE_O, DAT_NEAR_O, DAT_PSV_O, STK_VALID_O;
    logic STK_WRITE_O, ADDR_TRAP_O, STACK_TRAP_O;
    logic [23:0] DAT_ADDR_O;
    logic [8:0] wpg = 9'h001;
    logic [9:0] rpg = 10'h001;
    logic [15:0] sp_m = 16'h0800, lim_m = 16'h0000;
    logic [31:0] q;
    logic lim_ok = 1'b0;
    logic [29:0] dat_q[$];
    logic [34:0] stk_q[$];
    int take_q[$];
    int cyc = 0, failures = 0, checks_done = 0, t;
    eds_addr_stack eds_addr_stack_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
        .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
        .AVS_WRITE_I(AVS_WRITE_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
        .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
        .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .ACC_VALID_I(ACC_VALID_I),
        .ACC_WRITE_I(ACC_WRITE_I), .ACC_RMW_I(ACC_RMW_I),
        .ACC_USES_SP_I(ACC_USES_SP_I), .ACC_EA_I(ACC_EA_I),
        .ACC_READY_O(ACC_READY_O), .STK_PUSH_I(STK_PUSH_I),
        .STK_POP_I(STK_POP_I), .STK_SRC_I(STK_SRC_I),
        .STK_WDATA_I(STK_WDATA_I), .PC_I(PC_I), .SRL_I(SRL_I),
        .DAT_VALID_O(DAT_VALID_O), .DAT_WRITE_O(DAT_WRITE_O),
        .DAT_ADDR_O(DAT_ADDR_O), .DAT_NEAR_O(DAT_NEAR_O),
        .DAT_PSV_O(DAT_PSV_O), .STK_VALID_O(STK_VALID_O),
        .STK_WRITE_O(STK_WRITE_O), .STK_ADDR_O(STK_ADDR_O),
        .STK_WDATA_O(STK_WDATA_O), .ADDR_TRAP_O(ADDR_TRAP_O),
        .STACK_TRAP_O(STACK_TRAP_O));
    core_model core_model_i (.CLK_I(CLK_I), .ACC_READY_I(ACC_READY_O),
        .ACC_VALID_O(ACC_VALID_I), .ACC_WRITE_O(ACC_WRITE_I),
        .ACC_RMW_O(ACC_RMW_I), .ACC_USES_SP_O(ACC_USES_SP_I),
        .ACC_EA_O(ACC_EA_I));
    // clock and cycle count
    always #50 CLK_I = ~CLK_I;
    always @(posedge CLK_I) cyc <= cyc + 1;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // outputs are registered, so mid-cycle is where they are settled
    always @(negedge CLK_I) begin
        // take edge bumps cyc, so the note is the count before that edge
        if (RST_N_I && ACC_VALID_I && ACC_READY_O) take_q.push_back(cyc);
        if (DAT_VALID_O || ADDR_TRAP_O) begin
            t = take_q.size() ? take_q.pop_front() : 0;
            check({2'(cyc - t), ADDR_TRAP_O, DAT_VALID_O, ADDR_TRAP_O ? 26'h0 :
                {DAT_NEAR_O, DAT_WRITE_O, DAT_ADDR_O}},
                dat_q.size() ? dat_q.pop_front() : 30'h0);
        end
        if (STK_VALID_O || STACK_TRAP_O)
            check({STK_VALID_O, STACK_TRAP_O, STK_VALID_O ? {STK_WRITE_O,
                STK_ADDR_O, STK_WRITE_O ? STK_WDATA_O : 16'h0} : 33'h0},
                stk_q.size() ? stk_q.pop_front() : 35'h0);
    end
    // one avalon transfer, started just after an edge
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [15:0] d, output logic [31:0] rq);
        logic wt;
        AVS_READ_I      <= !wr;
        AVS_WRITE_I     <= wr;
        AVS_ADDRESS_I   <= a;
        AVS_WRITEDATA_I <= {rnd[31:16], d};
        do begin
            @(negedge CLK_I);
            wt = AVS_WAITREQUEST_O;
            rq = AVS_READDATA_O;
            @(posedge CLK_I);
        end while (wt);
        AVS_READ_I  <= 1'b0;
        AVS_WRITE_I <= 1'b0;
        @(posedge CLK_I);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 16'h0, q);
        check(q, e);
    endtask
    // note the expected access, then let the core model issue it
    task automatic acc(input logic w, input logic rmw, input logic sp,
                       input logic [15:0] ea);
        logic [8:0] pg;
        pg = (w && !rmw) ? wpg : rpg[8:0];
        if (ea[15] && pg == 9'h000)
            dat_q.push_back({2'd1, 2'b10, 26'h0});
        else
            dat_q.push_back({(ea[15] && !w) ? 2'd2 : 2'd1, 2'b01,
                ea < 16'h2000, w, ea[15] ? {pg, ea[14:0]} : {8'h00, ea}});
        core_model_i.issue(w, rmw, sp, ea);
    endtask
    // one stack op per call, back to back; the model tracks the pointer
    task automatic stk(input logic push, input eds_pkg::push_src_t src);
        logic [15:0] a, wd;
        rnd = lfsr(rnd);
        a = push ? sp_m : sp_m - 16'h0002;
        case (src)
            eds_pkg::SRC_DATA:    wd = rnd[15:0];
            eds_pkg::SRC_PC_LO:   wd = rnd[15:0];
            eds_pkg::SRC_PC_CALL: wd = {9'h000, rnd[22:16]};
            default:              wd = {rnd[31:24], 1'b0, rnd[22:16]};
        endcase
        stk_q.push_back({1'b1, a < 16'h0800 || (push && lim_ok &&
            sp_m > lim_m), push, a, push ? wd : 16'h0});
        sp_m = push ? sp_m + 16'h0002 : a;
        STK_PUSH_I  <= push;
        STK_POP_I   <= !push;
        STK_SRC_I   <= src;
        STK_WDATA_I <= rnd[15:0];
        PC_I        <= rnd[22:0];
        SRL_I       <= rnd[31:24];
        @(posedge CLK_I);
    endtask
    initial begin
        #(100 * 20000);
        failures++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        rd(5'h00, 32'h001);
        rd(5'h04, 32'h001);
        rd(5'h0c, 32'h0800);
        rd(5'h10, 32'h0);
        rd(5'h18, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            wpg = (rnd[8:0] == 9'h0) ? 9'h1ff : rnd[8:0];
            rpg = {1'b0, (rnd[24:16] == 9'h0) ? 9'h001 : rnd[24:16]};
            bus(1'b1, 5'h04, {7'h0, wpg}, q);
            bus(1'b1, 5'h00, {6'h0, rpg}, q);
            acc(1'b1, 1'b0, 1'b0, rnd[15:0] | 16'h8000);
            acc(1'b1, 1'b0, 1'b0, rnd[31:16] | 16'h8000);
            acc(1'b0, 1'b0, 1'b0, rnd[15:0] | 16'h8000);
            acc(1'b1, 1'b1, 1'b0, rnd[31:16] | 16'h8000);
            acc(1'b1, 1'b0, 1'b0, rnd[15:0] & 16'h7fff);
            acc(1'b0, 1'b0, 1'b0, rnd[31:16] & 16'h1fff);
            core_model_i.idle();
            rd(5'h14, {19'h0, rnd[28:16]});
        end
        acc(1'b1, 1'b0, 1'b0, 16'hffff);
        acc(1'b1, 1'b0, 1'b0, 16'h8000);
        core_model_i.idle();
        rd(5'h04, {23'h0, wpg});
        rd(5'h00, {22'h0, rpg});
        $display("test paged accesses done");
        wpg = 9'h000;
        rpg = 10'h000;
        bus(1'b1, 5'h04, 16'h0, q);
        bus(1'b1, 5'h00, 16'h0, q);
        acc(1'b1, 1'b0, 1'b0, 16'h8000);
        acc(1'b1, 1'b1, 1'b0, 16'hc000);
        acc(1'b1, 1'b0, 1'b0, 16'h7fff);
        core_model_i.idle();
        rd(5'h10, 32'h1);
        bus(1'b1, 5'h10, 16'h0001, q);
        rd(5'h10, 32'h0);
        $display("test address trap done");
        bus(1'b1, 5'h08, 16'h0805, q);
        lim_m = 16'h0804;
        lim_ok = 1'b1;
        rd(5'h08, 32'h0804);
        for (int i = 0; i < 4; i++)
            stk(1'b1, eds_pkg::push_src_t'(i[1:0]));
        for (int i = 0; i < 5; i++)
            stk(1'b0, eds_pkg::SRC_DATA);
        STK_POP_I <= 1'b0;
        stk_q.push_back({2'b01, 33'h0});
        acc(1'b0, 1'b0, 1'b1, 16'h0a00);
        core_model_i.idle();
        rd(5'h0c, 32'h07fe);
        rd(5'h10, 32'h2);
        $display("test stack checks done");
        repeat (3) @(posedge CLK_I);
        check(dat_q.size() + stk_q.size(), 0);
        end_sim();
    end
endmodule

// File: src/eds_addr_stack.sv
// data-space address generation, page checks and software stack checks
`timescale 1ns/1ps
// Operation
// - write with ea bit 15 set: write page bits 8:0 above ea bits 14:0
// - indirect pointer with bit 15 set goes through the loaded page register
// - page registers never change when a pointer wraps ffff to 8000
// - extended-space writes are issued in one cycle, no stall
// - read-modify-write takes its page from the read page register
// - addresses below 8000h ignore both pages, map straight to base space
// - access at or above 8000h with page 000h raises address error trap
// - pages 001h to 1ffh each select one 32-kbyte window from 008000h up
// - 0000h to 1fffh is the near region, reachable directly too
// - stack pointer marks next free word, push post-inc, pop pre-dec
// - call pushes pc upper byte zero-extended, top bit clear
// - exception push puts status low byte beside pc upper byte
// - stack limit not reset, bit 0 reads and holds zero from its first low-byte write
// - addresses formed from stack pointer are compared with stack limit
// - push at sp equal to limit is fine; next push beyond traps
// - stack address below 0800h raises stack error trap
// - read with ea bit 15 set, read page bit 9 clear: 24-bit address
// - extended-space read costs one extra cycle, two in all
module eds_addr_stack (
    // clock and reset
    input  wire logic                  CLK_I,
    input  wire logic                  RST_N_I,
    // avalon-mm register slave
    input  wire logic [4:0]            AVS_ADDRESS_I,
    input  wire logic                  AVS_READ_I,
    input  wire logic                  AVS_WRITE_I,
    input  wire logic [3:0]            AVS_BYTEENABLE_I,
    input  wire logic [31:0]           AVS_WRITEDATA_I,
    output logic      [31:0]           AVS_READDATA_O,
    output logic                       AVS_WAITREQUEST_O,
    // data access request from address generation
    input  wire logic                  ACC_VALID_I,
    input  wire logic                  ACC_WRITE_I,
    input  wire logic                  ACC_RMW_I,
    input  wire logic                  ACC_USES_SP_I,
    input  wire logic [15:0]           ACC_EA_I,
    output logic                       ACC_READY_O,
    // stack operation request
    input  wire logic                  STK_PUSH_I,
    input  wire logic                  STK_POP_I,
    input  wire eds_pkg::push_src_t    STK_SRC_I,
    input  wire logic [15:0]           STK_WDATA_I,
    input  wire logic [22:0]           PC_I,
    input  wire logic [7:0]            SRL_I,
    // data memory access out
    output logic                       DAT_VALID_O,
    output logic                       DAT_WRITE_O,
    output logic [23:0]                DAT_ADDR_O,
    output logic                       DAT_NEAR_O,
    output logic                       DAT_PSV_O,
    // stack memory access out
    output logic                       STK_VALID_O,
    output logic                       STK_WRITE_O,
    output logic [15:0]                STK_ADDR_O,
    output logic [15:0]                STK_WDATA_O,
    // trap requests
    output logic                       ADDR_TRAP_O,
    output logic                       STACK_TRAP_O
);

    // 24-bit address from a page and an effective address
    function automatic logic [23:0] page_addr(input logic [8:0]  page,
                                              input logic [15:0] ea);
        if (ea[15]) begin
            page_addr = {page, ea[14:0]};
        end else begin
            page_addr = {8'h00, ea};
        end
    endfunction

    // registers
    logic [9:0]  rpage_q;
    logic [8:0]  wpage_q;
    logic [15:0] limit_q;
    logic        limit_set_q;
    logic [15:0] sp_q;
    logic [1:0]  trap_stat_q;
    logic [23:0] last_addr_q;
    logic        waitreq_q;
    logic [31:0] rdata_q;
    logic        ready_q;
    logic [23:0] held_addr_q;
    logic        held_near_q;
    logic        held_psv_q;

    // bus decode
    logic        bus_req;
    logic        bus_take;
    logic        bus_wr;
    logic        lo_en;
    logic        hi_en;
    logic [15:0] wdata_lo;
    logic [31:0] rd_mux;
    assign bus_req  = AVS_READ_I | AVS_WRITE_I;
    assign bus_take = bus_req & ~waitreq_q;
    assign bus_wr   = AVS_WRITE_I & bus_take;
    assign lo_en    = AVS_BYTEENABLE_I[0];
    assign hi_en    = AVS_BYTEENABLE_I[1];
    assign wdata_lo = AVS_WRITEDATA_I[15:0];

    // read mux, unmapped offsets read zero
    always_comb begin
        unique case (AVS_ADDRESS_I)
            eds_pkg::OFF_RPAGE:     rd_mux = {22'h000000, rpage_q};
            eds_pkg::OFF_WPAGE:     rd_mux = {23'h000000, wpage_q};
            eds_pkg::OFF_STACK_LIM: rd_mux = {16'h0000, limit_q};
            eds_pkg::OFF_STACK_PTR: rd_mux = {16'h0000, sp_q};
            eds_pkg::OFF_TRAP_STAT: rd_mux = {30'h00000000, trap_stat_q};
            eds_pkg::OFF_LAST_ADDR: rd_mux = {8'h00, last_addr_q};
            default:                rd_mux = 32'h00000000;
        endcase
    end

    // access path decode
    logic        acc_take;
    logic        use_rpage;
    logic [8:0]  page_sel;
    logic        ext;
    logic        program_space_window;
    logic        page_bad;
    logic        eds_read;
    logic [23:0] acc_addr;
    assign acc_take  = ACC_VALID_I & ready_q;
    assign use_rpage = ~ACC_WRITE_I | ACC_RMW_I;
    assign page_sel  = use_rpage ? rpage_q[8:0] : wpage_q;
    assign ext       = ACC_EA_I[15];
    assign program_space_window       = ext & use_rpage & rpage_q[9];
    assign page_bad  = ext & ~program_space_window & (page_sel == eds_pkg::PAGE_NONE);
    assign eds_read  = ext & ~ACC_WRITE_I;
    assign acc_addr  = page_addr(page_sel, ACC_EA_I);

    // stack path decode
    logic [15:0] sp_dec;
    logic [15:0] stk_addr;
    logic [15:0] push_word;
    logic        over_limit;
    logic        under_floor;
    logic        sp_ea_over;
    logic        sp_ea_under;
    logic        stack_err;
    assign sp_dec   = sp_q - eds_pkg::SP_STEP;
    assign stk_addr = STK_PUSH_I ? sp_q : sp_dec;
    // push past the limit only; sp equal to limit is still legal
    assign over_limit  = STK_PUSH_I & limit_set_q & (sp_q > limit_q);
    assign under_floor = (STK_PUSH_I | STK_POP_I)
                       & (stk_addr < eds_pkg::STACK_FLOOR);
    assign sp_ea_over  = acc_take & ACC_USES_SP_I & limit_set_q
                       & (ACC_EA_I > limit_q);
    assign sp_ea_under = acc_take & ACC_USES_SP_I
                       & (ACC_EA_I < eds_pkg::STACK_FLOOR);
    assign stack_err   = over_limit | under_floor | sp_ea_over | sp_ea_under;

    // word pushed for each source
    always_comb begin
        unique case (STK_SRC_I)
            eds_pkg::SRC_DATA:    push_word = STK_WDATA_I;
            eds_pkg::SRC_PC_LO:   push_word = PC_I[15:0];
            eds_pkg::SRC_PC_CALL: push_word = {9'h000, PC_I[22:16]};
            eds_pkg::SRC_PC_EXC:  push_word = {SRL_I, 1'b0, PC_I[22:16]};
        endcase
    end

    // bus handshake: one wait cycle, then data stands with waitrequest low
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            waitreq_q <= 1'b1;
            rdata_q   <= 32'h00000000;
        end else begin
            waitreq_q <= ~(bus_req & waitreq_q);
            rdata_q   <= rd_mux;
        end
    end

    // page registers, written only by software, never by pointer wrap
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            rpage_q <= eds_pkg::RPAGE_RST;
            wpage_q <= eds_pkg::WPAGE_RST;
        end else if (bus_wr && AVS_ADDRESS_I == eds_pkg::OFF_RPAGE) begin
            if (lo_en) rpage_q[7:0] <= wdata_lo[7:0];
            if (hi_en) rpage_q[9:8] <= wdata_lo[9:8];
        end else if (bus_wr && AVS_ADDRESS_I == eds_pkg::OFF_WPAGE) begin
            if (lo_en) wpage_q[7:0] <= wdata_lo[7:0];
            if (hi_en) wpage_q[8]   <= wdata_lo[8];
        end
    end

    // stack limit keeps its value through reset; low-byte writes force bit 0 to zero
    always_ff @(posedge CLK_I) begin
        if (bus_wr && AVS_ADDRESS_I == eds_pkg::OFF_STACK_LIM) begin
            if (lo_en) limit_q[7:0]  <= {wdata_lo[7:1], 1'b0};
            if (hi_en) limit_q[15:8] <= wdata_lo[15:8];
        end
    end

    // limit checks stay off until software has loaded a limit
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            limit_set_q <= 1'b0;
        end else if (bus_wr && AVS_ADDRESS_I == eds_pkg::OFF_STACK_LIM) begin
            limit_set_q <= 1'b1;
        end
    end

    // stack pointer: post-increment push, pre-decrement pop
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            sp_q <= eds_pkg::SP_RST;
        end else if (STK_PUSH_I) begin
            sp_q <= sp_q + eds_pkg::SP_STEP;
        end else if (STK_POP_I) begin
            sp_q <= sp_dec;
        end else if (bus_wr && AVS_ADDRESS_I == eds_pkg::OFF_STACK_PTR) begin
            sp_q <= {wdata_lo[15:1], 1'b0};
        end
    end

    // stack memory request, one cycle per operation
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            STK_VALID_O <= 1'b0;
            STK_WRITE_O <= 1'b0;
            STK_ADDR_O  <= 16'h0000;
            STK_WDATA_O <= 16'h0000;
        end else begin
            STK_VALID_O <= STK_PUSH_I | STK_POP_I;
            STK_WRITE_O <= STK_PUSH_I;
            STK_ADDR_O  <= stk_addr;
            STK_WDATA_O <= push_word;
        end
    end

    // data access: writes go out at once, extended reads wait one cycle
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ready_q     <= 1'b1;
            held_addr_q <= 24'h000000;
            held_near_q <= 1'b0;
            held_psv_q  <= 1'b0;
            DAT_VALID_O <= 1'b0;
            DAT_WRITE_O <= 1'b0;
            DAT_ADDR_O  <= 24'h000000;
            DAT_NEAR_O  <= 1'b0;
            DAT_PSV_O   <= 1'b0;
            last_addr_q <= 24'h000000;
        end else if (!ready_q) begin
            ready_q     <= 1'b1;
            DAT_VALID_O <= 1'b1;
            DAT_WRITE_O <= 1'b0;
            DAT_ADDR_O  <= held_addr_q;
            DAT_NEAR_O  <= held_near_q;
            DAT_PSV_O   <= held_psv_q;
        end else if (acc_take && eds_read && !page_bad) begin
            ready_q     <= 1'b0;
            held_addr_q <= acc_addr;
            held_near_q <= 1'b0;
            held_psv_q  <= program_space_window;
            last_addr_q <= acc_addr;
            DAT_VALID_O <= 1'b0;
        end else begin
            DAT_VALID_O <= acc_take & ~page_bad;
            DAT_WRITE_O <= ACC_WRITE_I;
            DAT_ADDR_O  <= acc_addr;
            DAT_NEAR_O  <= ACC_EA_I < eds_pkg::NEAR_TOP;
            DAT_PSV_O   <= 1'b0;
            if (acc_take) last_addr_q <= acc_addr;
        end
    end

    // trap pulses and sticky status; a new error beats a clear
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ADDR_TRAP_O  <= 1'b0;
            STACK_TRAP_O <= 1'b0;
            trap_stat_q  <= 2'b00;
        end else begin
            ADDR_TRAP_O  <= acc_take & page_bad;
            STACK_TRAP_O <= stack_err;
            if (bus_wr && AVS_ADDRESS_I == eds_pkg::OFF_TRAP_STAT && lo_en) begin
                trap_stat_q <= trap_stat_q & ~wdata_lo[1:0];
            end
            if (acc_take && page_bad) trap_stat_q[eds_pkg::TRAP_ADDR_BIT] <= 1'b1;
            if (stack_err) trap_stat_q[eds_pkg::TRAP_STACK_BIT] <= 1'b1;
        end
    end

    // outputs straight from flip-flops
    assign AVS_READDATA_O    = rdata_q;
    assign AVS_WAITREQUEST_O = waitreq_q;
    assign ACC_READY_O       = ready_q;

    chk_write_page_join: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        acc_take && ACC_WRITE_I && !ACC_RMW_I && ext && !page_bad && ready_q
        |=> DAT_VALID_O && DAT_ADDR_O == {$past(wpage_q), $past(ACC_EA_I[14:0])})
        else $error("write address not built from write page");

    chk_rmw_read_page: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        acc_take && ACC_RMW_I && ext && !page_bad
        |=> DAT_ADDR_O[23:15] == $past(rpage_q[8:0]))
        else $error("read-modify-write did not use read page");

    chk_base_direct: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        acc_take && !ext && ready_q |=> DAT_ADDR_O == {8'h00, $past(ACC_EA_I)})
        else $error("base address was paged");

    chk_page_zero_trap: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        acc_take && ext && !program_space_window && page_sel == 9'h000
        |=> ADDR_TRAP_O && !DAT_VALID_O)
        else $error("page zero did not trap");

    chk_read_extra_cycle: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        acc_take && eds_read && !page_bad && ready_q
        |=> !ready_q && !DAT_VALID_O ##1 DAT_VALID_O && !DAT_WRITE_O && ready_q)
        else $error("extended read not delayed one cycle");

    chk_write_no_stall: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        acc_take && ACC_WRITE_I |=> ready_q && DAT_VALID_O == !ADDR_TRAP_O)
        else $error("write stalled the core");

    chk_push_post_inc: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        STK_PUSH_I |=> sp_q == $past(sp_q) + 16'h0002
            && STK_ADDR_O == $past(sp_q) && STK_WRITE_O)
        else $error("push did not post-increment");

    chk_limit_equal_ok: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        STK_PUSH_I && limit_set_q && sp_q == limit_q && sp_q >= 16'h0800
        && !(acc_take && ACC_USES_SP_I)
        |=> !STACK_TRAP_O and (STK_PUSH_I |=> STACK_TRAP_O))
        else $error("limit push trapped or next push did not");

    chk_underflow_trap: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        STK_POP_I && !STK_PUSH_I && sp_dec < 16'h0800 |=> STACK_TRAP_O)
        else $error("stack underflow did not trap");

    chk_call_msb_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        STK_PUSH_I && STK_SRC_I == eds_pkg::SRC_PC_CALL
        |=> STK_WDATA_O[15:7] == 9'h000)
        else $error("call push upper bits not clear");

    chk_limit_bit0_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        limit_set_q |-> limit_q[0] == 1'b0)
        else $error("stack limit bit 0 set");

    chk_trap_one_cycle: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        ADDR_TRAP_O |-> $past(acc_take) && !$past(ready_q) == 1'b0)
        else $error("address trap without a taken access");

endmodule
